// ==== lcd_segment_pin_config.sv ====
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_pin_map.svh"
// What this block does
// - map bit one: segment driver, zero: io
// - byte 2023 maps segments 31..24
// - byte 2024 maps segments 39..32
// - byte 2025 maps segments 47..40
// - byte 2026 bits 2..0 map 50..48
// - byte 2027 maps 63..61, 59..56; bit4 unused
// - byte 2028 maps segments 71..64
// - small package: absent pins' map bits inert
// - blink mask hides segment 18 commons
// - divider selects base divide 512 to 64
// - contrast code drops voltage 0.2 V/step
// - disabled display grounds bias, commons, segments
// - bias field selects scheme and common count
module lcd_segment_pin_config #(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  // avalon-mm slave, byte addresses
  input  wire logic [15:0]       address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [3:0]        byteenable,
  input  wire logic [31:0]       writedata,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  // shared pins, bit i = segment 24+i = io line 4+i
  output lcd_pin_pkg::role_map_t segRole,
  input  wire logic [47:0]       gioOeReq,
  output logic      [47:0]       gioOe,
  // analog and mode settings
  output lcd_pin_pkg::contrast_t contrastCode,
  output logic      [10:0]       contrastDropMv,
  output logic      [2:0]        biasSelect,
  output logic                   displayEnable,
  output logic                   driveTick,
  output logic                   driveClk,
  // drive waveform in, gated pads out
  input  wire logic [2:0]        biasIn,
  input  wire logic [3:0]        comIn,
  input  wire logic [71:0]       segIn,
  input  wire logic [3:0]        seg18OnIn,
  output logic      [2:0]        biasOut,
  output logic      [3:0]        comOut,
  output logic      [71:0]       segOut,
  output logic      [3:0]        seg18OnOut
);
  import lcd_pin_pkg::*;

  // ==========================================
  // bus handshake
  // every access takes two cycles: the first registers read data,
  // the second drops waitrequest so the master samples it
  bus_state_e busState_q;
  bus_state_e busState_d;
  wire        access   = read | write;
  wire        fire     = access && busState_q == BUS_ANSWER;
  wire        writeHit = write && fire && byteenable[0];
  wire [13:0] regIdx   = address[15:2];
  wire        aligned  = address[1:0] == 2'b00;

  always_comb begin
    busState_d = busState_q;
    unique case (busState_q)
      BUS_IDLE: begin
        if (access) busState_d = BUS_ANSWER;
      end
      BUS_ANSWER: begin
        busState_d = BUS_IDLE;
      end
    endcase
  end

  assign waitrequest = access && busState_q == BUS_IDLE;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busState_q <= BUS_IDLE;
    end else begin
      busState_q <= busState_d;
    end
  end

  // ==========================================
  // address decode
  wire selCtrl     = aligned && regIdx == `IDX_CTRL;
  wire selMap3124  = aligned && regIdx == `IDX_MAP_31_24;
  wire selMap3932  = aligned && regIdx == `IDX_MAP_39_32;
  wire selMap4740  = aligned && regIdx == `IDX_MAP_47_40;
  wire selMap5048  = aligned && regIdx == `IDX_MAP_50_48;
  wire selMap6356  = aligned && regIdx == `IDX_MAP_63_56;
  wire selMap7164  = aligned && regIdx == `IDX_MAP_71_64;
  wire selBlink    = aligned && regIdx == `IDX_BLINK;
  wire selContrast = aligned && regIdx == `IDX_CONTRAST;

  wire [7:0] wrByte = writedata[7:0];

  // ==========================================
  // configuration registers
  logic [5:0] ctrl_q;
  logic [7:0] map3124_q;
  logic [7:0] map3932_q;
  logic [7:0] map4740_q;
  logic [2:0] map5048_q;
  logic [6:0] map6356_q;
  logic [7:0] map7164_q;
  logic [3:0] blink_q;
  logic [2:0] contrast_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `RST_CTRL;
    end else if (writeHit && selCtrl) begin
      ctrl_q <= wrByte[5:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      map3124_q <= `RST_BYTE;
      map3932_q <= `RST_BYTE;
      map4740_q <= `RST_BYTE;
    end else begin
      if (writeHit && selMap3124) map3124_q <= wrByte;
      if (writeHit && selMap3932) map3932_q <= wrByte;
      if (writeHit && selMap4740) map4740_q <= wrByte;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      map5048_q <= 3'h0;
      map6356_q <= 7'h00;
      map7164_q <= `RST_BYTE;
    end else begin
      if (writeHit && selMap5048) map5048_q <= wrByte[2:0];
      if (writeHit && selMap6356) map6356_q <= {wrByte[7:5], wrByte[3:0]};
      if (writeHit && selMap7164) map7164_q <= wrByte;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blink_q    <= 4'h0;
      contrast_q <= 3'h0;
    end else begin
      if (writeHit && selBlink) blink_q <= wrByte[3:0];
      if (writeHit && selContrast) begin
        contrast_q <= wrByte[`CONTRAST_LSB +: 3];
      end
    end
  end

  // ==========================================
  // read-back
  // unused positions and unmapped addresses read zero
  wire [7:0] rdCtrl     = {2'b00, ctrl_q};
  wire [7:0] rdMap5048  = {5'h00, map5048_q};
  wire [7:0] rdMap6356  = {map6356_q[6:4], 1'b0, map6356_q[3:0]};
  wire [7:0] rdBlink    = {4'h0, blink_q};
  wire [7:0] rdContrast = {4'h0, contrast_q, 1'b0};
  wire [7:0] rdByte =
    selCtrl     ? rdCtrl     :
    selMap3124  ? map3124_q  :
    selMap3932  ? map3932_q  :
    selMap4740  ? map4740_q  :
    selMap5048  ? rdMap5048  :
    selMap6356  ? rdMap6356  :
    selMap7164  ? map7164_q  :
    selBlink    ? rdBlink    :
    selContrast ? rdContrast : 8'h00;

  logic [31:0] readdata_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata_q <= 32'h0000_0000;
    end else if (read && busState_q == BUS_IDLE) begin
      readdata_q <= {24'h00_0000, rdByte};
    end
  end
  assign readdata = readdata_q;

  // ==========================================
  // pin roles
  // the map holds no bits for segments 51..55 and 60: those pads are io only
  wire [47:0] rawRole = {map7164_q, map6356_q[6:4], 1'b0, map6356_q[3:0], 5'h00,
                         map5048_q, map4740_q, map3932_q, map3124_q};
  // stored bits for absent pads still read back, they just drive nothing
  wire [47:0] absentMask = LARGE_PACKAGE ? 48'h0 : `SMALL_PKG_ABSENT;
  assign segRole = rawRole & ~absentMask;

  genvar gi;
  generate
    for (gi = 0; gi < 48; gi++) begin : g_pad
      // io driver released while the pad is a segment, restored same cycle
      assign gioOe[gi] = gioOeReq[gi] & ~segRole[gi];
    end
  endgenerate

  // ==========================================
  // analog and mode outputs
  assign contrastCode   = contrast_q;
  assign contrastDropMv = 11'(contrast_q) * `STEP_MV;
  assign biasSelect     = ctrl_q[`CTRL_MODE_LSB +: 3];
  assign displayEnable  = ctrl_q[`CTRL_EN_BIT];

  // ==========================================
  // submodules
  lcd_cfg_if cfgBus ();
  assign cfgBus.displayEnable = ctrl_q[`CTRL_EN_BIT];
  assign cfgBus.divSel        = drive_div_e'(ctrl_q[`CTRL_DIV_LSB +: 2]);
  assign cfgBus.blinkMask     = blink_q;
  assign driveTick            = cfgBus.driveTick;
  assign driveClk             = cfgBus.driveClk;

  lcd_drive_divider u_div (
    .clk   (clk),
    .rst_n (rst_n),
    .cfg   (cfgBus)
  );

  lcd_output_gate u_gate (
    .clk        (clk),
    .rst_n      (rst_n),
    .cfg        (cfgBus),
    .biasIn     (biasIn),
    .comIn      (comIn),
    .segIn      (segIn),
    .seg18OnIn  (seg18OnIn),
    .biasOut    (biasOut),
    .comOut     (comOut),
    .segOut     (segOut),
    .seg18OnOut (seg18OnOut)
  );

  // ==========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_write_at(logic [13:0] idx);
    write && !waitrequest && byteenable[0] && aligned && regIdx == idx;
  endsequence

  property p_role_oe;
    (gioOe & segRole) == 48'h0 && (gioOe | segRole) == (gioOeReq | segRole);
  endproperty
  a_role_oe: assert property (p_role_oe) else $error("io driver not released");

  property p_map3124;
    s_write_at(`IDX_MAP_31_24) |=> rawRole[7:0] == $past(writedata[7:0]);
  endproperty
  a_map3124: assert property (p_map3124) else $error("map 31..24 not stored");

  property p_map3932;
    s_write_at(`IDX_MAP_39_32) |=> rawRole[15:8] == $past(writedata[7:0]);
  endproperty
  a_map3932: assert property (p_map3932) else $error("map 39..32 not stored");

  property p_map5048;
    s_write_at(`IDX_MAP_50_48) |=> rawRole[26:24] == $past(writedata[2:0])
                                   && rawRole[31:27] == 5'h00;
  endproperty
  a_map5048: assert property (p_map5048) else $error("map 50..48 wrong");

  property p_map6356;
    s_write_at(`IDX_MAP_63_56) |=> rawRole[35:32] == $past(writedata[3:0])
                                   && rawRole[39:37] == $past(writedata[7:5]) && !rawRole[36];
  endproperty
  a_map6356: assert property (p_map6356) else $error("map 63..56 wrong");

  property p_map7164;
    s_write_at(`IDX_MAP_71_64) |=> segRole[47:40] == ($past(writedata[7:0]) & ~absentMask[47:40]);
  endproperty
  a_map7164: assert property (p_map7164) else $error("map 71..64 not applied");

  property p_absent;
    (segRole & absentMask) == 48'h0;
  endproperty
  a_absent: assert property (p_absent) else $error("absent pad took segment role");

  property p_contrast;
    s_write_at(`IDX_CONTRAST) |=> contrastCode == $past(writedata[3:1])
                                  && contrastDropMv == 11'(contrastCode) * 11'd200;
  endproperty
  a_contrast: assert property (p_contrast) else $error("contrast code wrong");

  sequence s_read_ctrl;
    read && waitrequest && aligned && regIdx == `IDX_CTRL;
  endsequence
  property p_read_ctrl;
    s_read_ctrl ##1 (read && !waitrequest) |-> readdata == {26'h0, ctrl_q};
  endproperty
  a_read_ctrl: assert property (p_read_ctrl) else $error("mode register read wrong");

  property p_answer_time;
    access && waitrequest |=> !waitrequest || !access;
  endproperty
  a_answer_time: assert property (p_answer_time) else $error("answer not in two cycles");

  property p_reset_clear;
    $rose(rst_n) |-> segRole == 48'h0 && ctrl_q == 6'h00 && blink_q == 4'h0;
  endproperty
  a_reset_clear: assert property (@(posedge clk) p_reset_clear)
    else $error("fields not zero after reset");

  property p_map4740;
    s_write_at(`IDX_MAP_47_40) |=> rawRole[23:16] == $past(writedata[7:0]);
  endproperty
  a_map4740: assert property (p_map4740) else $error("map 47..40 not stored");

  property p_blink_store;
    s_write_at(`IDX_BLINK) |=> blink_q == $past(writedata[3:0]);
  endproperty
  a_blink_store: assert property (p_blink_store) else $error("blink mask not stored");

  property p_ctrl_store;
    s_write_at(`IDX_CTRL) |=> biasSelect == $past(writedata[4:2])
                              && displayEnable == $past(writedata[5]);
  endproperty
  a_ctrl_store: assert property (p_ctrl_store) else $error("mode fields not stored");

  // a write with byte lane 0 off must leave every field alone
  property p_refused;
    write && !waitrequest && !byteenable[0]
      |=> $stable(ctrl_q) && $stable(blink_q) && $stable(contrast_q) && $stable(rawRole);
  endproperty
  a_refused: assert property (p_refused) else $error("masked write changed a field");

  sequence s_read_odd;
    read && waitrequest && !aligned;
  endsequence
  property p_read_odd;
    s_read_odd ##1 (read && !waitrequest) |-> readdata == 32'h0000_0000;
  endproperty
  a_read_odd: assert property (p_read_odd) else $error("unaligned read not zero");
endmodule
`default_nettype wire

// ==== lcd_pin_map.svh ====
`ifndef LCD_PIN_MAP_SVH
`define LCD_PIN_MAP_SVH
// ==========================================
// register indices (byte address = 4 * index)
`define IDX_CTRL      14'h2021
`define IDX_MAP_31_24 14'h2023
`define IDX_MAP_39_32 14'h2024
`define IDX_MAP_47_40 14'h2025
`define IDX_MAP_50_48 14'h2026
`define IDX_MAP_63_56 14'h2027
`define IDX_MAP_71_64 14'h2028
`define IDX_BLINK     14'h205a
`define IDX_CONTRAST  14'h20ab
// ==========================================
// field positions
`define CTRL_DIV_LSB  0
`define CTRL_MODE_LSB 2
`define CTRL_EN_BIT   5
`define CONTRAST_LSB  1
// ==========================================
// reset values
`define RST_CTRL      6'h00
`define RST_BYTE      8'h00
// ==========================================
// timing and analog steps
`define CLK_HZ        32'd40000000
`define BASE_HZ       32'd32768
`define STEP_MV       11'd200
`define BLINK_TICKS   16'h0100
// pins that exist only on the larger package (bit i = segment 24 + i)
`define SMALL_PKG_ABSENT 48'h044f_0104_0100
`endif

// ==== lcd_pin_pkg.sv ====
package lcd_pin_pkg;
  // ==========================================
  // types
  typedef enum logic [1:0] {
    DIV_512 = 2'b00,
    DIV_256 = 2'b01,
    DIV_128 = 2'b10,
    DIV_64  = 2'b11
  } drive_div_e;
  typedef enum logic {
    BUS_IDLE   = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_e;
  typedef logic [47:0] role_map_t;
  typedef logic [2:0]  contrast_t;
endpackage

// ==== lcd_cfg_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface lcd_cfg_if;
  import lcd_pin_pkg::*;
  logic       displayEnable;
  drive_div_e divSel;
  logic [3:0] blinkMask;
  logic       driveTick;
  logic       driveClk;
  logic       blinkOff;
  modport cfg    (output displayEnable, divSel, blinkMask,
                  input driveTick, driveClk, blinkOff);
  modport timing (input divSel, output driveTick, driveClk, blinkOff);
  modport gate   (input displayEnable, blinkMask, blinkOff);
endinterface
`default_nettype wire

// ==== lcd_drive_divider.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lcd_pin_map.svh"
module lcd_drive_divider (
  input  wire logic  clk,
  input  wire logic  rst_n,
  lcd_cfg_if.timing  cfg
);
  import lcd_pin_pkg::*;
  // ==========================================
  // base tick: phase accumulator, no 32768 Hz clock in this domain
  logic [31:0] acc_q;
  logic [8:0]  divCnt_q;
  logic [15:0] blinkCnt_q;
  logic        tick_q;
  logic        dclk_q;
  logic        blink_q;
  wire  [32:0] accSum   = {1'b0, acc_q} + {1'b0, `BASE_HZ};
  wire         baseTick = accSum >= {1'b0, `CLK_HZ};
  // ten bits: divide-by-512 must not fold to zero in the half-period compare
  wire  [9:0]  divisor  = 10'h200 >> cfg.divSel;
  wire         wrap     = baseTick && divCnt_q == 9'h000;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= 32'h0; divCnt_q <= 9'h000; tick_q <= 1'b0;
      dclk_q <= 1'b0; blinkCnt_q <= 16'h0; blink_q <= 1'b0;
    end else begin
      acc_q    <= baseTick ? 32'(accSum - {1'b0, `CLK_HZ}) : accSum[31:0];
      divCnt_q <= !baseTick ? divCnt_q
                            : (wrap ? 9'(divisor - 10'h001) : divCnt_q - 9'h001);
      tick_q   <= wrap;
      if (wrap || (baseTick && divCnt_q == 9'(divisor >> 1))) dclk_q <= ~dclk_q;
      blinkCnt_q <= tick_q ? (blinkCnt_q == `BLINK_TICKS - 16'h1 ? 16'h0 : blinkCnt_q + 16'h1)
                           : blinkCnt_q;
      if (tick_q && blinkCnt_q == `BLINK_TICKS - 16'h1) blink_q <= ~blink_q;
    end
  end
  assign cfg.driveTick = tick_q;
  assign cfg.driveClk  = dclk_q;
  assign cfg.blinkOff  = blink_q;
  property p_div_reload;
    @(posedge clk) disable iff (!rst_n) wrap |=> divCnt_q == $past(9'(divisor - 10'h001));
  endproperty
  a_div_reload: assert property (p_div_reload) else $error("drive divider reload wrong");
endmodule
`default_nettype wire

// ==== lcd_output_gate.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcd_output_gate (
  input  wire logic        clk,
  input  wire logic        rst_n,
  lcd_cfg_if.gate          cfg,
  input  wire logic [2:0]  biasIn,
  input  wire logic [3:0]  comIn,
  input  wire logic [71:0] segIn,
  input  wire logic [3:0]  seg18OnIn,
  output logic      [2:0]  biasOut,
  output logic      [3:0]  comOut,
  output logic      [71:0] segOut,
  output logic      [3:0]  seg18OnOut
);
  // ==========================================
  // grounding and blink, registered so the pads see no glitches
  wire [3:0] blinkHide = cfg.blinkMask & {4{cfg.blinkOff}};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      biasOut <= 3'h0; comOut <= 4'h0; segOut <= 72'h0; seg18OnOut <= 4'h0;
    end else begin
      biasOut    <= cfg.displayEnable ? biasIn : 3'h0;
      comOut     <= cfg.displayEnable ? comIn : 4'h0;
      segOut     <= cfg.displayEnable ? segIn : 72'h0;
      seg18OnOut <= cfg.displayEnable ? (seg18OnIn & ~blinkHide) : 4'h0;
    end
  end
  property p_disable_ground;
    @(posedge clk) disable iff (!rst_n)
      !cfg.displayEnable |=> biasOut == 3'h0 && comOut == 4'h0 && segOut == 72'h0;
  endproperty
  a_disable_ground: assert property (p_disable_ground) else $error("outputs not grounded");
  property p_blink_hide;
    @(posedge clk) disable iff (!rst_n)
      cfg.displayEnable && cfg.blinkOff |=> (seg18OnOut & $past(cfg.blinkMask)) == 4'h0;
  endproperty
  a_blink_hide: assert property (p_blink_hide) else $error("blink segment visible");
endmodule
`default_nettype wire

// ==== lcd_glass_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// far side: drive waveform source and io logic requests
module lcd_glass_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  output logic      [2:0]  biasIn,
  output logic      [3:0]  comIn,
  output logic      [71:0] segIn,
  output logic      [3:0]  seg18OnIn,
  output logic      [47:0] gioOeReq
);
  logic [71:0] patQ;
  // pattern moves every cycle so a stale registered pad never matches by luck
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      patQ <= 72'h5a_c3f0_9e17_b2d4_6a1c;
    end else begin
      patQ <= {patQ[70:0], patQ[71] ^ patQ[64] ^ patQ[3] ^ patQ[0]};
    end
  end
  assign segIn     = patQ;
  assign biasIn    = patQ[71:69] ^ patQ[2:0];
  assign comIn     = patQ[10:7];
  assign seg18OnIn = patQ[40:37];
  assign gioOeReq  = ~patQ[60:13];
endmodule
`default_nettype wire

// ==== test_lcd_segment_pin_config.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lcd_pin_map.svh"
module test_lcd_segment_pin_config;
  import lcd_pin_pkg::*;
  logic        clk, rst_n, read, write;
  logic [15:0] address;
  logic [3:0]  byteenable;
  logic [31:0] writedata, readdata, expWord;
  logic        waitrequest, displayEnable, driveTick, driveClk;
  role_map_t   segRole;
  contrast_t   contrastCode;
  logic [47:0] gioOeReq, gioOe, expRole;
  logic [10:0] contrastDropMv;
  logic [2:0]  biasSelect, biasIn, biasOut;
  logic [3:0]  comIn, comOut, seg18OnIn, seg18OnOut;
  logic [71:0] segIn, segOut;
  logic [31:0] expQ[$];
  int          miscompares, totalChecks, seed;
  logic [13:0] mapIdx [6];
  logic [7:0]  useMask [6];
  logic [7:0]  d;
  role_map_t   smallRole;
  int          tickWait, gap, flips;
  logic        lastClk;
  // ==========================================
  // clock, instances
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  lcd_segment_pin_config uut (
    .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .segRole(segRole), .gioOeReq(gioOeReq), .gioOe(gioOe),
    .contrastCode(contrastCode), .contrastDropMv(contrastDropMv),
    .biasSelect(biasSelect), .displayEnable(displayEnable), .driveTick(driveTick),
    .driveClk(driveClk), .biasIn(biasIn), .comIn(comIn), .segIn(segIn),
    .seg18OnIn(seg18OnIn), .biasOut(biasOut), .comOut(comOut), .segOut(segOut),
    .seg18OnOut(seg18OnOut)
  );
  lcd_glass_model glass (
    .clk(clk), .rst_n(rst_n), .biasIn(biasIn), .comIn(comIn), .segIn(segIn),
    .seg18OnIn(seg18OnIn), .gioOeReq(gioOeReq)
  );
  // small package variant shares the bus, only its roles are watched
  lcd_segment_pin_config #(.LARGE_PACKAGE(1'b0)) smallPkg (
    .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(), .waitrequest(),
    .segRole(smallRole), .gioOeReq(gioOeReq), .gioOe(), .contrastCode(),
    .contrastDropMv(), .biasSelect(), .displayEnable(), .driveTick(), .driveClk(),
    .biasIn(biasIn), .comIn(comIn), .segIn(segIn), .seg18OnIn(seg18OnIn),
    .biasOut(), .comOut(), .segOut(), .seg18OnOut()
  );
  // ==========================================
  // compare and closing
  task automatic checkPin(input string name, input logic [71:0] exp, input logic [71:0] got);
    totalChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic checkRead(input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH readdata expected %h seen %h", exp, got);
    end
  endtask
  task automatic complete_run;
    if (miscompares == 0 && totalChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========================================
  // avalon master: hold until waitrequest is seen low at a rising edge
  function automatic logic [15:0] a(input logic [13:0] idx);
    return {idx, 2'b00};
  endfunction
  task automatic waitAnswer;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) miscompares++;
  endtask
  task automatic busWrite(input logic [15:0] adr, input logic [7:0] data, input logic [3:0] be);
    @(posedge clk);
    address    <= adr;
    writedata  <= {$random(seed), data} & 32'h0000_ffff;
    byteenable <= be;
    write      <= 1'b1;
    waitAnswer();
    write <= 1'b0;
  endtask
  task automatic busRead(input logic [15:0] adr, input logic [7:0] exp);
    @(posedge clk);
    expQ.push_back({24'h0, exp});
    address <= adr;
    read    <= 1'b1;
    waitAnswer();
    read <= 1'b0;
  endtask
  // read results come off the queue in issue order
  always @(posedge clk) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      expWord = (expQ.size() > 0) ? expQ.pop_front() : 32'hdead_beef;
      checkRead(expWord, readdata);
    end
  end
  // pads are registered: compare with the inputs one edge earlier
  task automatic checkPads(input logic en);
    logic [71:0] s;
    logic [3:0]  c, o;
    logic [2:0]  b;
    @(negedge clk);
    s = en ? segIn : 72'h0;
    c = en ? comIn : 4'h0;
    o = en ? seg18OnIn : 4'h0;
    b = en ? biasIn : 3'h0;
    @(negedge clk);
    checkPin("segOut", s, segOut);
    checkPin("comOut", {68'h0, c}, {68'h0, comOut});
    checkPin("biasOut", {69'h0, b}, {69'h0, biasOut});
    checkPin("seg18OnOut", {68'h0, o}, {68'h0, seg18OnOut});
  endtask
  function automatic logic [47:0] placeMap(input int k, input logic [7:0] v, input logic [47:0] m);
    case (k)
      0: m[7:0] = v;
      1: m[15:8] = v;
      2: m[23:16] = v;
      3: m[26:24] = v[2:0];
      4: m[39:32] = {v[7:5], 1'b0, v[3:0]};
      default: m[47:40] = v;
    endcase
    return m;
  endfunction
  // ==========================================
  // watchdog and main sequence
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    complete_run();
  end
  initial begin
    seed = 32'h2f96;
    rst_n = 1'b0; read = 1'b0; write = 1'b0;
    address = 16'h0; byteenable = 4'h0; writedata = 32'h0;
    miscompares = 0; totalChecks = 0; expRole = 48'h0;
    mapIdx  = '{`IDX_MAP_31_24, `IDX_MAP_39_32, `IDX_MAP_47_40,
                `IDX_MAP_50_48, `IDX_MAP_63_56, `IDX_MAP_71_64};
    useMask = '{8'hff, 8'hff, 8'hff, 8'h07, 8'hef, 8'hff};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // every field starts at zero, every pin in the io role
    foreach (mapIdx[k]) busRead(a(mapIdx[k]), 8'h00);
    busRead(a(`IDX_CTRL), 8'h00);
    busRead(a(`IDX_BLINK), 8'h00);
    busRead(a(`IDX_CONTRAST), 8'h00);
    @(negedge clk);
    checkPin("segRole", 72'h0, {24'h0, segRole});
    checkPin("gioOe", {24'h0, gioOeReq}, {24'h0, gioOe});
    checkPads(1'b0);
    // round 0 all ones hits unused bits, round 3 zero reconnects drivers
    for (int r = 0; r < 4; r++) begin
      foreach (mapIdx[k]) begin
        d = (r == 0) ? 8'hff : (r == 3) ? 8'h00 : $random(seed);
        if (r != 0) d = d & useMask[k];
        busWrite(a(mapIdx[k]), d, 4'h1);
        expRole = placeMap(k, d & useMask[k], expRole);
        busRead(a(mapIdx[k]), d & useMask[k]);
        @(negedge clk);
        checkPin("segRole", {24'h0, expRole}, {24'h0, segRole});
        checkPin("gioOe", {24'h0, gioOeReq & ~expRole}, {24'h0, gioOe});
        checkPin("smallRole", {24'h0, expRole & ~`SMALL_PKG_ABSENT}, {24'h0, smallRole});
      end
    end
    // refused accesses
    busWrite(a(`IDX_BLINK), 8'h05, 4'h1);
    busWrite(a(`IDX_BLINK), 8'h0a, 4'h0);
    busRead(a(`IDX_BLINK), 8'h05);
    busWrite(a(14'h2022), 8'hff, 4'h1);
    busRead(a(14'h2022), 8'h00);
    busRead(a(`IDX_CTRL) | 16'h0001, 8'h00);
    busRead(a(`IDX_CTRL), 8'h00);
    // every contrast code and its drop
    for (int c = 0; c < 8; c++) begin
      busWrite(a(`IDX_CONTRAST), 8'(c << 1), 4'h1);
      busRead(a(`IDX_CONTRAST), 8'(c << 1));
      checkPin("contrastCode", 72'(c), 72'(contrastCode));
      checkPin("contrastDropMv", 72'(c * 200), 72'(contrastDropMv));
    end
    // enable toggles each pass, bias random, divider random except fixed at 64 on the last pass
    for (int i = 0; i < 8; i++) begin
      d = {2'b00, i[0], 5'($random(seed))};
      if (i == 7) d[1:0] = 2'b11;
      busWrite(a(`IDX_CTRL), d, 4'h1);
      busWrite(a(`IDX_BLINK), 8'($random(seed)) & 8'h0f, 4'h1);
      busRead(a(`IDX_CTRL), d);
      checkPin("biasSelect", 72'(d[4:2]), 72'(biasSelect));
      checkPin("displayEnable", 72'(d[5]), 72'(displayEnable));
      // blink phase never flips in a run this short, so masked bits pass through
      checkPads(d[5]);
    end
    // second reset; fastest drive clock set before the first base tick
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    busRead(a(`IDX_CTRL), 8'h00);
    busWrite(a(`IDX_CTRL), 8'h23, 4'h1);
    tickWait = 0;
    do begin
      @(posedge clk);
      tickWait++;
    end while (driveTick !== 1'b1 && tickWait < 2000);
    gap = 0;
    flips = 0;
    lastClk = driveClk;
    do begin
      @(posedge clk);
      gap++;
      if (driveClk !== lastClk) flips++;
      lastClk = driveClk;
    end while (driveTick !== 1'b1 && gap < 80000);
    // 64 base periods of 32768 Hz at 40 MHz
    checkPin("driveTickGap", 72'd78125, 72'(gap));
    checkPin("driveClkFlips", 72'd2, 72'(flips));
    repeat (4) @(posedge clk);
    checkPin("pendingReads", 72'h0, 72'(expQ.size()));
    complete_run();
  end
endmodule
`default_nettype wire
